// ==== common/tps_map.svh ====
// Register offsets, field positions, reset values and counts of the timer block.
`ifndef TPS_MAP_SVH
`define TPS_MAP_SVH

`define TPS_ADDR_COUNT    4'h0
`define TPS_ADDR_OPTION   4'h1
`define TPS_ADDR_IRQCTL   4'h2

`define TPS_BIT_CSS       5
`define TPS_BIT_EDGE      4
`define TPS_BIT_PSA       3
`define TPS_RATIO_HI      2
`define TPS_RATIO_LO      0
`define TPS_BIT_IRQ_EN    5
`define TPS_BIT_OVF       2

`define TPS_OPTION_RST    6'h3F
`define TPS_COUNT_RST     8'h00
`define TPS_COUNT_MAX     8'hFF
`define TPS_BYTE_ZERO     8'h00
`define TPS_INHIBIT_CYC   2'h2
`define TPS_INHIBIT_NONE  2'h0
`define TPS_INHIBIT_STEP  2'h1
`define TPS_RATIO_EXTRA   4'h1

`endif

// ==== common/tps_pkg.sv ====
// Types shared by the timer core and its prescaler.
package tps_pkg;

  typedef logic [7:0] tps_byte_t;
  typedef logic [3:0] tps_addr_t;

  typedef enum logic [3:0] {
    TPS_PH_Q1 = 4'h1,
    TPS_PH_Q2 = 4'h2,
    TPS_PH_Q3 = 4'h4,
    TPS_PH_Q4 = 4'h8
  } tps_phase_e;

  typedef struct packed {
    tps_phase_e phase;
    tps_byte_t  count;
    logic       count_source_sel;
    logic       source_edge_sel;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio_sel;
    logic       overflow_irq_en;
    logic       overflow_flag;
    logic [1:0] inhibit;
    logic       ext_pol;
    logic       sample;
    logic       wdt_tick;
    tps_byte_t  rdata;
  } tps_core_s;

  typedef struct packed {
    tps_byte_t cnt;
  } tps_pre_s;

endpackage : tps_pkg

// ==== rtl/tps_prescaler.sv ====
// Eight-bit prescaler counter shared by the timer and the watchdog.
`include "tps_map.svh"

module tps_prescaler (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic              clr_i,
  input  wire logic              adv_i,
  output tps_pkg::tps_byte_t     count_o
);
  import tps_pkg::*;

  tps_pre_s s_q;
  tps_pre_s s_d;

  // Every stage toggles on the same clock, so each tap is a square wave of even duty.
  always_comb begin
    s_d = s_q;
    if (clr_i) begin
      s_d.cnt = `TPS_BYTE_ZERO;
    end else if (adv_i) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_clear_wins;
    clr_i |=> (count_o == 8'h00);
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("prescaler not cleared");

  property p_hold;
    !clr_i && !adv_i |=> $stable(count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("prescaler moved without advance");

endmodule : tps_prescaler

// ==== rtl/tps_core.sv ====
// Eight-bit timer/counter with a prescaler shared with the watchdog.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`include "tps_map.svh"

// Contract
// - Count register is eight bits, readable and writable by software any time.
// - Timer mode without prescaler advances once every instruction cycle.
// - A count write blocks counting for the next two instruction cycles.
// - Counter mode advances on external count input edges instead.
// - Edge select clear means rising edges count; set means falling edges.
// - Assign bit clear gives prescaler to timer, set gives it to watchdog.
// - Timer prescale ratios are powers of two from 1:2 to 1:256.
// - Prescaler is an eight-bit counter with no software access.
// - Wrap from maximum to zero sets the overflow flag.
// - Overflow request reaches the processor only while its enable is set.
// - Timer stops in sleep, so its overflow never wakes the processor.
// - External path is sampled at the second and fourth phase clocks.
// - Prescaler on the external input gives a symmetrical output.
// - Count updates three to seven oscillator periods after an input edge; here it updates one to three clock periods after.
// - Timer-assigned prescaler clears on every count register write.
// - Watchdog-assigned prescaler clears with the watchdog clear instruction.
module tps_core (
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire tps_pkg::tps_addr_t addr_i,
  input  wire tps_pkg::tps_byte_t wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output tps_pkg::tps_byte_t     rdata_o,
  input  wire logic              ext_count_input_i,
  input  wire logic              sleep_i,
  input  wire logic              watchdog_clear_instr_i,
  input  wire logic              wdt_tick_i,
  output logic                   wdt_post_tick_o,
  output logic                   overflow_irq_o
);
  import tps_pkg::*;

  tps_core_s s_q;
  tps_core_s s_d;
  tps_byte_t pre_cnt;
  logic      wr_count;
  logic      wr_option;
  logic      wr_irqctl;
  logic      at_q2;
  logic      at_q4;
  logic      ext_pol;
  logic      src_evt;
  logic      pre_adv;
  logic      pre_clr;
  logic [3:0] ratio_k;
  logic      sync_lvl;
  logic      run;
  logic      inc;

  // True when the low k bits of the prescaler are all ones.
  function automatic logic term_hit(input tps_byte_t p, input logic [3:0] k);
    logic [8:0] m;
    m = (9'h001 << k) - 9'h001;
    return &(p | ~m[7:0]);
  endfunction : term_hit

  assign wr_count  = wr_i && (addr_i == `TPS_ADDR_COUNT);
  assign wr_option = wr_i && (addr_i == `TPS_ADDR_OPTION);
  assign wr_irqctl = wr_i && (addr_i == `TPS_ADDR_IRQCTL);
  assign at_q2     = (s_q.phase == TPS_PH_Q2);
  assign at_q4     = (s_q.phase == TPS_PH_Q4);

  // A set edge select inverts the pin, so a rising internal level is always the counted edge.
  assign ext_pol = ext_count_input_i ^ s_q.source_edge_sel;
  assign src_evt = s_q.count_source_sel ? (ext_pol && !s_q.ext_pol) : at_q4;

  // The prescaler serves exactly one user at a time.
  assign pre_adv = s_q.prescaler_assign ? wdt_tick_i : (src_evt && !sleep_i);
  assign pre_clr = (wr_count && !s_q.prescaler_assign)
                 || (watchdog_clear_instr_i && s_q.prescaler_assign);

  // Timer ratio needs one more stage than the watchdog ratio.
  assign ratio_k = {1'b0, s_q.prescale_ratio_sel}
                 + (s_q.prescaler_assign ? 4'h0 : `TPS_RATIO_EXTRA);

  // Tap n of the prescaler has a period of 2^(n+1) input edges and even duty.
  assign sync_lvl = s_q.prescaler_assign ? ext_pol
                                         : pre_cnt[s_q.prescale_ratio_sel];

  // Sleep stops the count outright, so no overflow can be raised to wake the core.
  assign run = !sleep_i && (s_q.inhibit == `TPS_INHIBIT_NONE);

  always_comb begin
    inc = 1'b0;
    if (run) begin
      if (s_q.count_source_sel) begin
        inc = (at_q2 || at_q4) && sync_lvl && !s_q.sample;
      end else begin
        inc = at_q4 && (s_q.prescaler_assign || term_hit(pre_cnt, ratio_k));
      end
    end
  end

  tps_prescaler u_pre (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .clr_i   (pre_clr),
    .adv_i   (pre_adv),
    .count_o (pre_cnt)
  );

  always_comb begin
    s_d = s_q;
    s_d.ext_pol  = ext_pol;
    s_d.rdata    = `TPS_BYTE_ZERO;
    s_d.wdt_tick = s_q.prescaler_assign && wdt_tick_i && term_hit(pre_cnt, ratio_k);

    if (!sleep_i) begin
      case (s_q.phase)
        TPS_PH_Q1: s_d.phase = TPS_PH_Q2;
        TPS_PH_Q2: s_d.phase = TPS_PH_Q3;
        TPS_PH_Q3: s_d.phase = TPS_PH_Q4;
        TPS_PH_Q4: s_d.phase = TPS_PH_Q1;
        default:   s_d.phase = TPS_PH_Q1;
      endcase
      if (at_q2 || at_q4) begin
        s_d.sample = sync_lvl;
      end
      if (at_q4 && (s_q.inhibit != `TPS_INHIBIT_NONE)) begin
        s_d.inhibit = s_q.inhibit - `TPS_INHIBIT_STEP;
      end
    end

    if (wr_count) begin
      s_d.count   = wdata_i;
      s_d.inhibit = `TPS_INHIBIT_CYC;
    end else if (inc) begin
      s_d.count = s_q.count + 8'h01;
    end

    if (wr_option) begin
      s_d.count_source_sel   = wdata_i[`TPS_BIT_CSS];
      s_d.source_edge_sel    = wdata_i[`TPS_BIT_EDGE];
      s_d.prescaler_assign   = wdata_i[`TPS_BIT_PSA];
      s_d.prescale_ratio_sel = wdata_i[`TPS_RATIO_HI:`TPS_RATIO_LO];
    end

    if (wr_irqctl) begin
      s_d.overflow_irq_en = wdata_i[`TPS_BIT_IRQ_EN];
      s_d.overflow_flag   = wdata_i[`TPS_BIT_OVF];
    end
    // A wrap in the same cycle as a software clear keeps the flag set.
    if (inc && !wr_count && (s_q.count == `TPS_COUNT_MAX)) begin
      s_d.overflow_flag = 1'b1;
    end

    if (rd_i) begin
      case (addr_i)
        `TPS_ADDR_COUNT: s_d.rdata = s_q.count;
        `TPS_ADDR_OPTION: begin
          s_d.rdata[`TPS_BIT_CSS]                 = s_q.count_source_sel;
          s_d.rdata[`TPS_BIT_EDGE]                = s_q.source_edge_sel;
          s_d.rdata[`TPS_BIT_PSA]                 = s_q.prescaler_assign;
          s_d.rdata[`TPS_RATIO_HI:`TPS_RATIO_LO]  = s_q.prescale_ratio_sel;
        end
        `TPS_ADDR_IRQCTL: begin
          s_d.rdata[`TPS_BIT_IRQ_EN] = s_q.overflow_irq_en;
          s_d.rdata[`TPS_BIT_OVF]    = s_q.overflow_flag;
        end
        default: s_d.rdata = `TPS_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.phase              <= TPS_PH_Q1;
      s_q.count              <= `TPS_COUNT_RST;
      {s_q.count_source_sel, s_q.source_edge_sel, s_q.prescaler_assign,
       s_q.prescale_ratio_sel} <= `TPS_OPTION_RST;
      s_q.overflow_irq_en    <= 1'b0;
      s_q.overflow_flag      <= 1'b0;
      s_q.inhibit            <= `TPS_INHIBIT_NONE;
      // Both edge trackers start high, so a pin resting at either level cannot pass for a
      // counted edge in the first cycles after reset.
      s_q.ext_pol            <= 1'b1;
      s_q.sample             <= 1'b1;
      s_q.wdt_tick           <= 1'b0;
      s_q.rdata              <= `TPS_BYTE_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o         = s_q.rdata;
  assign wdt_post_tick_o = s_q.wdt_tick;
  assign overflow_irq_o  = s_q.overflow_irq_en && s_q.overflow_flag;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_write_count;
    wr_count |=> (s_q.count == $past(wdata_i)) && (s_q.inhibit == 2'h2);
  endproperty
  a_write_count: assert property (p_write_count) else $error("count write lost");

  property p_inhibit;
    (s_q.inhibit != 2'h0) && !wr_count |=> $stable(s_q.count);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved while inhibited");

  property p_timer_rate;
    at_q4 && !s_q.count_source_sel && s_q.prescaler_assign && (s_q.inhibit == 2'h0)
      && !sleep_i && !wr_count |=> (s_q.count == $past(s_q.count) + 8'h01);
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer missed a cycle");

  property p_timer_off_q4;
    !s_q.count_source_sel && !at_q4 && !wr_count |=> $stable(s_q.count);
  endproperty
  a_timer_off_q4: assert property (p_timer_off_q4) else $error("timer moved off cycle end");

  property p_sleep;
    sleep_i && !wr_count |=> $stable(s_q.count);
  endproperty
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");

  property p_ext_sample;
    s_q.count_source_sel && !wr_count && !at_q2 && !at_q4 |=> $stable(s_q.count);
  endproperty
  a_ext_sample: assert property (p_ext_sample) else $error("count moved off sample point");

  property p_overflow;
    inc && !wr_count && (s_q.count == 8'hFF) |=> s_q.overflow_flag && (s_q.count == 8'h00);
  endproperty
  a_overflow: assert property (p_overflow) else $error("wrap did not set flag");

  property p_irq_mask;
    !s_q.overflow_irq_en |-> !overflow_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request seen");

  property p_pre_clear_timer;
    wr_count && !s_q.prescaler_assign |=> (pre_cnt == 8'h00);
  endproperty
  a_pre_clear_timer: assert property (p_pre_clear_timer) else $error("prescaler kept count");

  property p_pre_clear_wdt;
    watchdog_clear_instr_i && s_q.prescaler_assign |=> (pre_cnt == 8'h00);
  endproperty
  a_pre_clear_wdt: assert property (p_pre_clear_wdt) else $error("watchdog clear missed");

  property p_ratio_timer;
    !s_q.prescaler_assign && !s_q.count_source_sel && (s_q.prescale_ratio_sel == 3'h0)
      && at_q4 && run && !wr_count && !pre_cnt[0] |=> $stable(s_q.count);
  endproperty
  a_ratio_timer: assert property (p_ratio_timer) else $error("1:2 ratio counted early");

  c_overflow:  cover property (inc && (s_q.count == 8'hFF));
  c_ext_inc:   cover property (s_q.count_source_sel && inc);
  c_wdt_tick:  cover property (s_q.wdt_tick);
  c_write_inh: cover property (wr_count ##1 (s_q.inhibit != 2'h0) [*4]);

endmodule : tps_core

// ==== verification/tps_ext_src.sv ====
// External count source that drives the timer's count pin.
module tps_ext_src (
  input  wire logic mclk_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_o = 1'b0;
  // The pin rests low between bursts, as a stopped source would.
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge mclk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge mclk_i);
      pin_o <= 1'b0;
    end
  endtask : pulses
endmodule : tps_ext_src

// ==== verification/timer0_with_shared_prescaler_tb.sv ====
// Self-checking bench for the timer core with a cycle reference model.
`include "tps_map.svh"
module timer0_with_shared_prescaler_tb import tps_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic      mclk_i, nrst_i, wr_i, rd_i, sleep_i, wdc_i, tick_i, pin, post_o, irq_o;
  tps_addr_t addr_i;
  tps_byte_t wdata_i, rdata_o, m_cnt, m_pre, exp_rd, mk;
  logic [1:0] m_ph, m_inh;
  logic [5:0] m_opt;
  logic       m_en, m_flg, m_post;
  int         num_errors = 0;
  int         n_compared = 0;
  integer     seed = 32'hc30e7cdd;

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  tps_core dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_count_input_i(pin),
    .sleep_i(sleep_i), .watchdog_clear_instr_i(wdc_i), .wdt_tick_i(tick_i),
    .wdt_post_tick_o(post_o), .overflow_irq_o(irq_o));
  tps_ext_src src (.mclk_i(mclk_i), .pin_o(pin));

  task automatic chk(input string nm, input tps_byte_t seen, input tps_byte_t exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Terminal mask of the prescaler for the current owner and ratio.
  always_comb mk = (m_opt[3] ? 8'h01 << m_opt[2:0] : 8'h02 << m_opt[2:0]) - 8'h01;

  // Counter-mode edges are not modelled; those results are checked by count instead.
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_ph <= 2'h0;
      m_inh <= 2'h0;
      m_cnt <= 8'h00;
      m_pre <= 8'h00;
      m_opt <= 6'h3F;
      m_en <= 1'b0;
      m_flg <= 1'b0;
      m_post <= 1'b0;
      exp_rd <= 8'h00;
    end else begin
      chk("irq", {7'h00, irq_o}, {7'h00, m_en & m_flg});
      if (m_opt[3])
        chk("post", {7'h00, post_o}, {7'h00, m_post});
      m_post <= m_opt[3] && tick_i && (m_pre & mk) == mk;
      exp_rd <= 8'h00;
      if (rd_i)
        case (addr_i)
          `TPS_ADDR_COUNT: exp_rd <= m_cnt;
          `TPS_ADDR_OPTION: exp_rd <= {2'h0, m_opt};
          `TPS_ADDR_IRQCTL: exp_rd <= {2'h0, m_en, 2'h0, m_flg, 2'h0};
          default: exp_rd <= 8'h00;
        endcase
      if (wdc_i && m_opt[3])
        m_pre <= 8'h00;
      else if (m_opt[3] && tick_i)
        m_pre <= m_pre + 8'h01;
      if (!sleep_i)
        m_ph <= m_ph + 2'h1;
      // The software clear is applied first, so a wrap in the same cycle still sets the flag.
      if (wr_i && addr_i == `TPS_ADDR_IRQCTL) begin
        m_en <= wdata_i[5];
        m_flg <= wdata_i[2];
      end
      if (wr_i && addr_i == `TPS_ADDR_COUNT) begin
        m_cnt <= wdata_i;
        m_inh <= 2'h2;
        if (!m_opt[3])
          m_pre <= 8'h00;
      end else if (m_ph == 2'h3 && !sleep_i) begin
        if (!m_opt[3] && !m_opt[5])
          m_pre <= m_pre + 8'h01;
        if (m_inh != 2'h0)
          m_inh <= m_inh - 2'h1;
        else if (!m_opt[5] && (m_opt[3] || (m_pre & mk) == mk)) begin
          m_cnt <= m_cnt + 8'h01;
          if (m_cnt == 8'hFF)
            m_flg <= 1'b1;
        end
      end
      if (wr_i && addr_i == `TPS_ADDR_OPTION)
        m_opt <= wdata_i[5:0];
    end
  end

  // Writes land in a Q1 cycle so they never meet a counting Q4 edge.
  task automatic reg_wr(input tps_addr_t a, input tps_byte_t d);
    do @(posedge mclk_i); while (m_ph != 2'h3 || sleep_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : reg_wr

  task automatic wd_clear();
    @(posedge mclk_i);
    wdc_i <= 1'b1;
    @(posedge mclk_i);
    wdc_i <= 1'b0;
  endtask : wd_clear

  task automatic reg_rd(input tps_addr_t a, output tps_byte_t v, output tps_byte_t e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    e = exp_rd;
  endtask : reg_rd

  task automatic rdm(input tps_addr_t a);
    tps_byte_t v, e;
    reg_rd(a, v, e);
    chk("rdata", v, e);
  endtask : rdm

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    wrap_up();
  end

  initial begin
    tps_byte_t v, e;
    int k;
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    sleep_i = 1'b0;
    wdc_i = 1'b0;
    tick_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rdm(`TPS_ADDR_COUNT);
    rdm(`TPS_ADDR_OPTION);
    rdm(`TPS_ADDR_IRQCTL);
    reg_wr(4'hF, 8'hFF);
    rdm(4'hF);
    $display("test registers done");
    reg_wr(`TPS_ADDR_OPTION, 8'h08);
    for (k = 0; k < 4; k++) begin
      reg_wr(`TPS_ADDR_COUNT, 8'($random(seed)));
      repeat ({$random(seed)} % 12) @(posedge mclk_i);
      rdm(`TPS_ADDR_COUNT);
      rdm(`TPS_ADDR_COUNT);
    end
    $display("test timer done");
    wd_clear();
    for (k = 0; k < 8; k++) begin
      reg_wr(`TPS_ADDR_OPTION, 8'(k));
      reg_wr(`TPS_ADDR_COUNT, 8'h10);
      repeat (12 << k) @(posedge mclk_i);
      rdm(`TPS_ADDR_COUNT);
    end
    $display("test ratios done");
    reg_wr(`TPS_ADDR_COUNT, 8'h00);
    wd_clear();
    reg_wr(`TPS_ADDR_OPTION, 8'h08);
    reg_wr(`TPS_ADDR_COUNT, 8'hFD);
    repeat (24) @(posedge mclk_i);
    rdm(`TPS_ADDR_IRQCTL);
    reg_wr(`TPS_ADDR_IRQCTL, 8'h24);
    rdm(`TPS_ADDR_IRQCTL);
    reg_wr(`TPS_ADDR_IRQCTL, 8'h20);
    rdm(`TPS_ADDR_IRQCTL);
    $display("test overflow done");
    @(posedge mclk_i);
    sleep_i <= 1'b1;
    repeat (40) @(posedge mclk_i);
    rdm(`TPS_ADDR_COUNT);
    sleep_i <= 1'b0;
    $display("test sleep done");
    for (k = 0; k < 4; k++) begin
      if (k == 2)
        wd_clear();
      reg_wr(`TPS_ADDR_OPTION, {2'h0, 1'b1, k[0], ~k[1], 3'h0});
      repeat (8) @(posedge mclk_i);
      reg_wr(`TPS_ADDR_COUNT, 8'h40);
      repeat (12) @(posedge mclk_i);
      src.pulses(4, 3);
      repeat (10) @(posedge mclk_i);
      reg_rd(`TPS_ADDR_COUNT, v, e);
      chk("counter", v, k[1] ? 8'h42 : 8'h44);
    end
    $display("test counter done");
    reg_wr(`TPS_ADDR_COUNT, 8'h00);
    wd_clear();
    reg_wr(`TPS_ADDR_OPTION, 8'h08 | 8'({$random(seed)} % 8));
    rdm(`TPS_ADDR_OPTION);
    wd_clear();
    for (k = 0; k < 300; k++) begin
      tick_i <= 1'b1;
      @(posedge mclk_i);
      tick_i <= 1'b0;
      wdc_i <= (k == 150);
      @(posedge mclk_i);
      wdc_i <= 1'b0;
    end
    $display("test watchdog done");
    wrap_up();
  end
endmodule : timer0_with_shared_prescaler_tb
